// ==== logic/ksp_regs.sv ====
// keyscan port configuration, key status and display test register bank
// Notes on behaviour
// - shared pin is segment output or open-drain output (interrupt or host level)
// - config bits 7..5: 000 low, 001 high, 010 irq low, 011 irq high, 1xx segment
// - bit 4 selects scan input b mode, bit 3 scan input a; 1 is keyscan
// - config read returns allocation, modes, input b/a levels, and interrupt flag in bit 0
// - eight keys tracked with both inputs in keyscan, four with only one
// - debounced register holds one bit per key, set on debounce since last read
// - debounced register clears after being read; new bits OR in meanwhile
// - no event queue; only accumulated per-key bits are kept
// - reading the debounced register drops the interrupt
// - a held key is reported once; it must be seen released first
// - writes to the debounced register are discarded
// - pressed register reloads after every scan test with the latest samples
// - reading the pressed register changes nothing
// - writes to the pressed register are discarded
// - display test register bit 0: 0 normal, 1 display test
// - display test lights every led; port configuration stays in effect
// - display test forces duty 28/64 regardless of intensity
// - a key debounces when found pressed in two consecutive samples after being unpressed
// - only two keys per enabled digit are scanned
`timescale 1ns/100ps
module ksp_regs
   import ksp_pkg::*;
#(
   parameter int NUM_KEYS = 8
)(
   // clock, reset, enable
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   // register access from the serial interface engine
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // scan engine
   input  wire logic [1:0] scan_limit,
   input  wire logic       scan_stb,
   input  wire logic [7:0] scan_pressed,
   // input pins
   input  wire logic       scan_input_a,
   input  wire logic       scan_input_b,
   // shared pin, open drain: oe low means driven
   input  wire logic       seg_drive,
   output logic            shared_irq_segment_pin_o,
   output logic            shared_irq_segment_pin_oe_n,
   output logic            ninth_segment_output,
   // display control towards the led engine
   output logic            test_mode,
   output logic      [5:0] test_duty
);
   logic [2:0]          alloc_r;
   logic [1:0]          mode_r;
   logic                test_r;
   logic [7:0]          deb_r;
   logic [7:0]          prs_r;
   logic                irq_r;
   logic [NUM_KEYS-1:0] key_en;
   logic [NUM_KEYS-1:0] key_hit;
   logic [7:0]          new_deb;
   logic                rd_deb;
   logic                wr_cfg;
   logic                pin_lvl_nxt;
   logic                pin_oe_n_nxt;

   assign rd_deb = reg_rd && (reg_addr == KSP_ADDR_KEY_DEB);
   // writes to 0x08 and 0x0C decode to nothing
   assign wr_cfg = reg_wr && (reg_addr == KSP_ADDR_PORT_CFG);

   // key k sits on digit k%4 and on input a for k<4, input b for k>=4
   genvar k;
   generate
      for (k = 0; k < NUM_KEYS; k++) begin : g_key
         localparam logic [1:0] DIGIT = 2'(k % 4);
         assign key_en[k] = (DIGIT <= scan_limit)
                            && ((k < 4) ? mode_r[0] : mode_r[1]);
         ksp_key_track u_track (
            .sys_clk         (sys_clk),
            .rst_n           (rst_n),
            .clk_en          (clk_en),
            .enable          (key_en[k]),
            .sample_stb      (scan_stb),
            .pressed         (scan_pressed[k]),
            .debounced_pulse (key_hit[k])
         );
      end
   endgenerate
   assign new_deb = 8'(key_hit);

   // port configuration
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         alloc_r <= KSP_ALLOC_RST;
         mode_r  <= KSP_MODE_RST;
      end else if (clk_en && wr_cfg) begin
         alloc_r <= reg_wdata[KSP_ALLOC_MSB:KSP_ALLOC_LSB];
         mode_r  <= {reg_wdata[KSP_MODE_B_BIT], reg_wdata[KSP_MODE_A_BIT]};
      end
   end

   // display test
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         test_r <= 1'b0;
      end else if (clk_en && reg_wr && reg_addr == KSP_ADDR_DISP_TEST) begin
         test_r <= reg_wdata[KSP_TEST_BIT];
      end
   end

   // debounced latch: read clears, new hits in that cycle survive the clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         deb_r <= KSP_KEY_RST;
      end else if (clk_en) begin
         deb_r <= (rd_deb ? KSP_KEY_RST : deb_r) | new_deb;
      end
   end

   // interrupt flag: set wins over the read clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else if (clk_en) begin
         irq_r <= (irq_r && !rd_deb) || (|new_deb);
      end
   end

   // pressed register tracks the latest scan test only; reads never touch it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prs_r <= KSP_KEY_RST;
      end else if (clk_en && scan_stb) begin
         prs_r <= scan_pressed & 8'(key_en);
      end
   end

   // read data, registered; old debounced contents returned before the clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (clk_en && reg_rd) begin
         unique case (reg_addr)
            KSP_ADDR_PORT_CFG:  reg_rdata <= {alloc_r, mode_r[1], mode_r[0],
                                             scan_input_b, scan_input_a, irq_r};
            KSP_ADDR_DISP_TEST: reg_rdata <= {7'h00, test_r};
            KSP_ADDR_KEY_DEB:   reg_rdata <= deb_r;
            KSP_ADDR_KEY_PRS:   reg_rdata <= prs_r;
            default:            reg_rdata <= 8'h00;
         endcase
      end
   end

   // shared pin decode; config stays in effect in display test
   always_comb begin
      pin_lvl_nxt  = 1'b0;
      pin_oe_n_nxt = 1'b1;
      if (alloc_r[2]) begin
         pin_lvl_nxt  = 1'b0;
         pin_oe_n_nxt = 1'b1;
      end else begin
         unique case (alloc_r)
            KSP_ALLOC_LOW:   pin_oe_n_nxt = 1'b0;
            KSP_ALLOC_HIGH:  pin_oe_n_nxt = 1'b1;
            KSP_ALLOC_IRQ_L: pin_oe_n_nxt = !irq_r;
            KSP_ALLOC_IRQ_H: pin_oe_n_nxt = irq_r;
            default:         pin_oe_n_nxt = 1'b1;
         endcase
      end
   end

   // open drain: only low is actively driven, high is released to the pullup
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         shared_irq_segment_pin_o    <= 1'b0;
         shared_irq_segment_pin_oe_n <= 1'b1;
         ninth_segment_output        <= 1'b0;
      end else if (clk_en) begin
         shared_irq_segment_pin_o    <= pin_lvl_nxt;
         shared_irq_segment_pin_oe_n <= pin_oe_n_nxt;
         ninth_segment_output        <= alloc_r[2] && (seg_drive || test_r);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         test_mode <= 1'b0;
         test_duty <= 6'h00;
      end else if (clk_en) begin
         test_mode <= test_r;
         test_duty <= KSP_TEST_DUTY;
      end
   end

   // assertions
   sequence deb_read_s;
      clk_en && rd_deb && !(|new_deb);
   endsequence

   irq_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      deb_read_s |=> !irq_r)
      else $error("interrupt flag survived a debounced read");

   deb_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      deb_read_s |=> deb_r == 8'h00)
      else $error("debounced latch not cleared by read");

   deb_accum_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !rd_deb) |=> ((deb_r & $past(deb_r)) == $past(deb_r)))
      else $error("debounced bits lost without a read");

   irq_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && |new_deb) |=> irq_r)
      else $error("new debounce did not raise flag");

   prs_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_rd && reg_addr == KSP_ADDR_KEY_PRS && !scan_stb)
      |=> $stable(prs_r) && $stable(irq_r))
      else $error("pressed read disturbed state");

   ro_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && reg_wr && (reg_addr == KSP_ADDR_KEY_DEB || reg_addr == KSP_ADDR_KEY_PRS))
      |=> $stable(alloc_r) && $stable(mode_r) && $stable(test_r))
      else $error("write to read-only register had effect");

   irq_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && alloc_r == KSP_ALLOC_IRQ_L && irq_r) ##1 clk_en
      |-> !shared_irq_segment_pin_oe_n)
      else $error("active-low interrupt not driven");

   seg_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && alloc_r[2]) |=> shared_irq_segment_pin_oe_n)
      else $error("pin driven while allocated as segment");

   test_duty_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && test_r) |=> test_mode && test_duty == 6'h1C)
      else $error("display test duty wrong");

   // named steps shared by the checks below
   sequence cfg_write_s;
      clk_en && wr_cfg;
   endsequence

   sequence test_write_s;
      clk_en && reg_wr && reg_addr == KSP_ADDR_DISP_TEST;
   endsequence

   sequence prs_read_s;
      clk_en && reg_rd && reg_addr == KSP_ADDR_KEY_PRS;
   endsequence

   sequence cfg_read_s;
      clk_en && reg_rd && reg_addr == KSP_ADDR_PORT_CFG;
   endsequence

   cfg_alloc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_write_s
      |=> alloc_r == $past(reg_wdata[KSP_ALLOC_MSB:KSP_ALLOC_LSB]))
      else $error("pin allocation not taken from write");

   cfg_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_write_s
      |=> mode_r == $past({reg_wdata[KSP_MODE_B_BIT], reg_wdata[KSP_MODE_A_BIT]}))
      else $error("input modes not taken from write");

   test_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      test_write_s
      |=> test_r == $past(reg_wdata[KSP_TEST_BIT]))
      else $error("display test bit not taken from write");

   deb_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en
      |=> ((deb_r & $past(new_deb)) == $past(new_deb)))
      else $error("new debounce bit missing from latch");

   deb_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !rd_deb && !(|new_deb))
      |=> $stable(deb_r))
      else $error("debounced latch changed with no hit and no read");

   one_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && |new_deb)
      |=> !(|(new_deb & $past(new_deb))))
      else $error("held key reported twice in a row");

   prs_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && scan_stb)
      |=> prs_r == $past(scan_pressed & 8'(key_en)))
      else $error("pressed register not loaded from scan test");

   prs_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !scan_stb)
      |=> $stable(prs_r))
      else $error("pressed register changed between scan tests");

   prs_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      prs_read_s
      |=> reg_rdata == $past(prs_r) && $stable(deb_r))
      else $error("pressed read returned wrong data");

   cfg_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cfg_read_s
      |=> reg_rdata == $past({alloc_r, mode_r, scan_input_b, scan_input_a, irq_r}))
      else $error("configuration read returned wrong data");

   deb_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && rd_deb)
      |=> reg_rdata == $past(deb_r))
      else $error("debounced read did not return old contents");

   rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !reg_rd)
      |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   irq_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !rd_deb && irq_r)
      |=> irq_r)
      else $error("interrupt flag dropped without a read");

   irq_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && alloc_r == KSP_ALLOC_IRQ_H)
      |=> shared_irq_segment_pin_oe_n == $past(irq_r))
      else $error("active-high interrupt pin wrong");

   pin_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && alloc_r == KSP_ALLOC_LOW)
      |=> !shared_irq_segment_pin_oe_n)
      else $error("logic 0 allocation not driven low");

   pin_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clk_en && alloc_r == KSP_ALLOC_HIGH)
      |=> shared_irq_segment_pin_oe_n)
      else $error("logic 1 allocation not released");

   pin_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en
      |=> !shared_irq_segment_pin_o)
      else $error("open-drain pin drove a high level");

   seg_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en
      |=> ninth_segment_output == $past(alloc_r[2] && (seg_drive || test_r)))
      else $error("ninth segment output wrong");

   test_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en
      |=> test_mode == $past(test_r))
      else $error("display test mode output lags wrongly");

   // a frozen enable must hold the debounced latch, the flag and the allocation, read data included
   freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !clk_en
      |=> $stable(deb_r) && $stable(irq_r) && $stable(alloc_r) && $stable(reg_rdata))
      else $error("state moved while clock enable was low");
endmodule

// ==== inc/ksp_pkg.sv ====
// shared constants and types for the keyscan port and status register bank
package ksp_pkg;
   // register addresses
   localparam logic [7:0] KSP_ADDR_PORT_CFG  = 8'h06;
   localparam logic [7:0] KSP_ADDR_DISP_TEST = 8'h07;
   localparam logic [7:0] KSP_ADDR_KEY_DEB   = 8'h08;
   localparam logic [7:0] KSP_ADDR_KEY_PRS   = 8'h0C;
   // port configuration field positions
   localparam int KSP_ALLOC_MSB  = 7;
   localparam int KSP_ALLOC_LSB  = 5;
   localparam int KSP_MODE_B_BIT = 4;
   localparam int KSP_MODE_A_BIT = 3;
   localparam int KSP_LVL_B_BIT  = 2;
   localparam int KSP_LVL_A_BIT  = 1;
   localparam int KSP_IRQ_BIT    = 0;
   localparam int KSP_TEST_BIT   = 0;
   // reset values
   localparam logic [2:0] KSP_ALLOC_RST = 3'h4;
   localparam logic [1:0] KSP_MODE_RST  = 2'h0;
   localparam logic [7:0] KSP_KEY_RST   = 8'h00;
   // pin allocation codes on bits 7..5
   localparam logic [2:0] KSP_ALLOC_LOW   = 3'h0;
   localparam logic [2:0] KSP_ALLOC_HIGH  = 3'h1;
   localparam logic [2:0] KSP_ALLOC_IRQ_L = 3'h2;
   localparam logic [2:0] KSP_ALLOC_IRQ_H = 3'h3;
   // display test duty in 64ths
   localparam logic [5:0] KSP_TEST_DUTY = 6'h1C;
   // full scan / debounce cycle
   localparam int KSP_SCAN_MS     = 41;
   localparam int KSP_CLK_MHZ     = 100;
   localparam int KSP_SCAN_CYCLES = KSP_SCAN_MS * 1000 * KSP_CLK_MHZ;
   // key count per enabled digit
   localparam int KSP_KEYS_PER_DIGIT = 2;
   // debounce tracking states per key
   typedef enum logic [2:0] {
      KSP_KEY_IDLE = 3'b001,
      KSP_KEY_SEEN = 3'b010,
      KSP_KEY_HELD = 3'b100
   } ksp_key_state_t;
endpackage

// ==== logic/ksp_key_track.sv ====
// one-key debounce tracker: two consecutive pressed samples, report once per press
`timescale 1ns/100ps
module ksp_key_track
   import ksp_pkg::*;
(
   // clock and control
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   // per-key scan result
   input  wire logic enable,
   input  wire logic sample_stb,
   input  wire logic pressed,
   // result
   output logic      debounced_pulse
);
   ksp_key_state_t state_r;
   ksp_key_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      if (!enable) begin
         state_nxt = KSP_KEY_IDLE;
      end else if (sample_stb) begin
         unique case (state_r)
            KSP_KEY_IDLE: state_nxt = pressed ? KSP_KEY_SEEN : KSP_KEY_IDLE;
            KSP_KEY_SEEN: state_nxt = pressed ? KSP_KEY_HELD : KSP_KEY_IDLE;
            KSP_KEY_HELD: state_nxt = pressed ? KSP_KEY_HELD : KSP_KEY_IDLE;
            default:      state_nxt = KSP_KEY_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r <= KSP_KEY_IDLE;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   // pulses only on entry to held, so a held key is reported once
   assign debounced_pulse = clk_en && (state_r == KSP_KEY_SEEN)
                            && (state_nxt == KSP_KEY_HELD);
endmodule

// ==== bench/ksp_host_model.sv ====
// host bus model: turns a bench request into a one-cycle register access
`timescale 1ns/100ps
module ksp_host_model (
   // clock and bench request
   input  wire logic       sys_clk,
   input  wire logic       go,
   input  wire logic       is_wr,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   // access towards the device
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // outside an access the bus alternates every cycle between the inverse of the last value and the last value
   always @(posedge sys_clk) begin
      reg_wr <= go & is_wr;
      reg_rd <= go & ~is_wr;
      reg_addr <= go ? addr : ~reg_addr;
      reg_wdata <= go ? wdata : ~reg_wdata;
   end
endmodule

// ==== bench/test_ksp_regs.sv ====
// self-checking bench for the keyscan port and status register bank
`timescale 1ns/100ps
module test_ksp_regs;
   import ksp_pkg::*;
   logic        sys_clk, rst_n, clk_en, go, is_wr, scan_stb, seg_drive;
   logic        scan_input_a, scan_input_b, reg_wr, reg_rd;
   logic        pin_o, pin_oe_n, seg_out, test_mode;
   logic [7:0]  addr, wdata, reg_addr, reg_wdata, reg_rdata, scan_pressed, rd;
   logic [1:0]  scan_limit;
   logic [5:0]  test_duty;
   logic [31:0] seed = 32'd32;
   logic [31:0] rnd;
   int          miscompares = 0;
   int          cmp_count = 0;
   // reference model state
   logic [2:0]  alloc;
   logic [1:0]  modes;
   logic        test, flag;
   logic [7:0]  deb, prs;
   int          st[8];

   ksp_host_model ksp_host_model_i (.sys_clk(sys_clk), .go(go), .is_wr(is_wr), .addr(addr),
      .wdata(wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd));
   ksp_regs #(.NUM_KEYS(8)) ksp_regs_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .scan_limit(scan_limit), .scan_stb(scan_stb),
      .scan_pressed(scan_pressed), .scan_input_a(scan_input_a), .scan_input_b(scan_input_b),
      .seg_drive(seg_drive), .shared_irq_segment_pin_o(pin_o),
      .shared_irq_segment_pin_oe_n(pin_oe_n), .ninth_segment_output(seg_out),
      .test_mode(test_mode), .test_duty(test_duty));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic stop_test();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic pins();
      logic e;
      e = alloc[2] ? 1'b1 : alloc[1] ? (alloc[0] ? flag : ~flag) : alloc[0];
      chk({7'h0, pin_oe_n}, {7'h0, e});
      chk({7'h0, pin_o}, 8'h00);
      chk({7'h0, seg_out}, {7'h0, alloc[2] & (seg_drive | test)});
      chk({7'h0, test_mode}, {7'h0, test});
      chk({2'h0, test_duty}, {2'h0, KSP_TEST_DUTY});
   endtask

   // one access; the live inputs change with it and hold until the next
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      r = xs();
      @(posedge sys_clk);
      go <= 1'b1;
      is_wr <= w;
      addr <= a;
      wdata <= d;
      scan_input_a <= r[0];
      scan_input_b <= r[1];
      seg_drive <= r[2];
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      rd = reg_rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      access(1'b1, a, d);
      if (a == KSP_ADDR_PORT_CFG) begin
         alloc = d[7:5];
         modes = d[4:3];
      end
      if (a == KSP_ADDR_DISP_TEST) test = d[0];
      pins();
   endtask

   task automatic rdchk(input logic [7:0] a);
      logic [7:0] e;
      access(1'b0, a, xs());
      e = 8'h00;
      case (a)
         KSP_ADDR_PORT_CFG: e = {alloc, modes, scan_input_b, scan_input_a, flag};
         KSP_ADDR_DISP_TEST: e = {7'h0, test};
         KSP_ADDR_KEY_DEB: e = deb;
         KSP_ADDR_KEY_PRS: e = prs;
         default: e = 8'h00;
      endcase
      if (a == KSP_ADDR_DISP_TEST) rd = {7'h0, rd[0]};
      chk(rd, e);
      if (a == KSP_ADDR_KEY_DEB) begin
         deb = 8'h00;
         flag = 1'b0;
      end
      pins();
   endtask

   task automatic scan(input logic [7:0] p);
      logic [7:0] en;
      @(posedge sys_clk);
      scan_stb <= 1'b1;
      scan_pressed <= p;
      @(posedge sys_clk);
      scan_stb <= 1'b0;
      scan_pressed <= ~p;
      for (int k = 0; k < 8; k++) begin
         en[k] = ((k % 4) <= scan_limit) && modes[k / 4];
         if (!en[k] || !p[k]) st[k] = 0;
         else if (st[k] == 0) st[k] = 1;
         else if (st[k] == 1) begin
            st[k] = 2;
            deb[k] = 1'b1;
            flag = 1'b1;
         end
      end
      prs = p & en;
      repeat (3) @(posedge sys_clk);
      #1;
      pins();
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      #200000;
      miscompares++;
      stop_test();
   end

   initial begin
      {rst_n, go, is_wr, scan_stb, seg_drive, scan_input_a, scan_input_b} = 7'h00;
      {addr, wdata, scan_pressed} = 24'h000000;
      clk_en = 1'b1;
      scan_limit = 2'h3;
      {alloc, modes, test, flag} = {KSP_ALLOC_RST, KSP_MODE_RST, 2'h0};
      {deb, prs} = {KSP_KEY_RST, KSP_KEY_RST};
      foreach (st[k]) st[k] = 0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) rdchk(8'h06 + i[7:0]);
      // every pin allocation, display test on and off
      for (int i = 0; i < 16; i++) begin
         wr(KSP_ADDR_DISP_TEST, {7'h0, i[0]});
         wr(KSP_ADDR_PORT_CFG, {i[3:1], 2'h3, 3'h5});
         rdchk(KSP_ADDR_PORT_CFG);
      end
      // every input mode against every scan limit
      for (int i = 0; i < 16; i++) begin
         wr(KSP_ADDR_PORT_CFG, 8'h18);
         scan_limit <= 2'h3;
         scan(8'h00);
         rdchk(KSP_ADDR_KEY_DEB);
         scan_limit <= i[1:0];
         wr(KSP_ADDR_PORT_CFG, {3'h3, i[3:2], 3'h0});
         scan(8'hFF);
         scan(8'hFF);
         rdchk(KSP_ADDR_KEY_PRS);
         rdchk(KSP_ADDR_KEY_DEB);
      end
      wr(KSP_ADDR_PORT_CFG, 8'h58);
      scan_limit <= 2'h3;
      for (int i = 0; i < 150; i++) begin
         rnd = xs();
         case (rnd[2:0])
            3'h0, 3'h1, 3'h2: scan(rnd[15:8]);
            3'h3: rdchk(KSP_ADDR_KEY_DEB);
            3'h4: rdchk(KSP_ADDR_KEY_PRS);
            3'h5: rdchk(KSP_ADDR_PORT_CFG);
            3'h6: wr(rnd[8] ? KSP_ADDR_KEY_DEB : KSP_ADDR_KEY_PRS, rnd[31:24]);
            default: wr(KSP_ADDR_PORT_CFG, {2'h1, rnd[8], 2'h3, rnd[11:9]});
         endcase
      end
      // a write while the enable is low must be lost
      clk_en <= 1'b0;
      access(1'b1, KSP_ADDR_DISP_TEST, {7'h0, ~test});
      clk_en <= 1'b1;
      rdchk(KSP_ADDR_DISP_TEST);
      stop_test();
   end
endmodule
